// ---- rtl/pcdc_regs.sv ----
// read-only capability and device capability registers of the bridge
// Summary of operation
// [RULE_01] capability version nibble always reads 1h
// [RULE_02] port kind code in bits 7:4 reads 0111b, bridge type
// [RULE_03] slot implemented bit 8 is read-only zero
// [RULE_04] bits 15:9 of capability info read zero, writes ignored
// [RULE_05] power limit message loads payload bits 9:8 into scale field 27:26
// [RULE_06] scale encoding 00=1.0x, 01=0.1x, 10=0.01x, 11=0.001x
// [RULE_07] power limit message loads payload bits 7:0 into value field 25:18
// [RULE_08] role based error flag bit 15 hardwired one
// [RULE_09] lamp and button present bits 14:12 hardwired zero
// [RULE_10] deep idle latency 11:9 mirrors general control bits 15:13
// [RULE_11] standby latency 8:6 mirrors general control bits 18:16
// [RULE_12] both latency fields reset to 000b
// [RULE_13] latency below the phy exit latency is not accepted
// [RULE_14] ghost function support bits 4:3 read 00b
// [RULE_15] max payload support bits 2:0 read 010b, 512 bytes
// [RULE_16] bits 31:28 of device capability read zero
// [RULE_17] wide tag support bit 5 read-only, not supported
// [RULE_18] bits 17:16 of device capability read zero
// [RULE_19] captured fields hold until next message or reset to zero
`timescale 1ns/1ns
`default_nettype none
`include "pcdc_consts.svh"
module pcdc_regs #(
	parameter logic [2:0] DEEP_IDLE_PHY_MIN = 3'h0,
	parameter logic [2:0] STANDBY_PHY_MIN   = 3'h0
) (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// configuration write of the general control register
	input  wire logic        i_gc_wr,
	input  wire logic [31:0] i_gc_wdata,
	// set slot power limit message
	input  wire logic        i_pl_msg,
	input  wire logic [9:0]  i_pl_payload,
	// configuration read port
	input  wire logic        i_rd,
	input  wire logic [7:0]  i_rd_addr,
	output logic             o_rd_valid,
	output logic [31:0]      o_rd_data,
	// register images
	output logic [15:0]      o_cap_info,
	output logic [31:0]      o_dev_cap_info
);
	pcdc_pkg::pcdc_power_limit_s pl_r, pl_nxt;
	pcdc_pkg::pcdc_latency_s     lat_r, lat_nxt;
	logic [15:0] cap_nxt;
	logic [31:0] dev_nxt;
	logic        rd_valid_nxt;
	logic [31:0] rd_data_nxt;
	logic [2:0]  deep_req;
	logic [2:0]  stby_req;

	always_comb begin
		pl_nxt = pl_r; // RULE_19
		if (i_pl_msg) begin
			pl_nxt.captured_power_scale = i_pl_payload[`PCDC_PL_SCALE_HI:`PCDC_PL_SCALE_LO]; // RULE_05 RULE_06
			pl_nxt.captured_power_value = i_pl_payload[7:0]; // RULE_07
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			pl_r.captured_power_scale <= `PCDC_SCALE_RESET; // RULE_19
			pl_r.captured_power_value <= `PCDC_VALUE_RESET; // RULE_19
		end else begin
			pl_r <= pl_nxt;
		end
	end

	// values below the phy floor are dropped so the field keeps its prior setting
	always_comb begin
		lat_nxt  = lat_r;
		deep_req = i_gc_wdata[`PCDC_GC_DEEP_HI:`PCDC_GC_DEEP_LO];
		stby_req = i_gc_wdata[`PCDC_GC_STBY_HI:`PCDC_GC_STBY_LO];
		if (i_gc_wr) begin
			if (deep_req >= DEEP_IDLE_PHY_MIN) begin // RULE_13
				lat_nxt.deep_idle_exit_latency = deep_req; // RULE_10
			end
			if (stby_req >= STANDBY_PHY_MIN) begin // RULE_13
				lat_nxt.standby_exit_latency = stby_req; // RULE_11
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			lat_r.deep_idle_exit_latency <= `PCDC_LAT_RESET; // RULE_12
			lat_r.standby_exit_latency   <= `PCDC_LAT_RESET; // RULE_12
		end else begin
			lat_r <= lat_nxt;
		end
	end

	always_comb begin
		cap_nxt = {7'h00, // RULE_04
			1'h0, // RULE_03
			`PCDC_PORT_KIND_CODE, // RULE_02
			`PCDC_CAP_VERSION}; // RULE_01
		dev_nxt = {4'h0, // RULE_16
			pl_nxt.captured_power_scale,
			pl_nxt.captured_power_value,
			2'h0, // RULE_18
			`PCDC_ROLE_ERR_FLAG, // RULE_08
			3'h0, // RULE_09
			lat_nxt.deep_idle_exit_latency,
			lat_nxt.standby_exit_latency,
			`PCDC_WIDE_TAG_SUPPORT, // RULE_17
			`PCDC_GHOST_FUNC_SUPPORT, // RULE_14
			`PCDC_MAX_PAYLOAD_SUPPORT}; // RULE_15
	end

	// images mirror next state so they track the capture with no extra lag
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_cap_info     <= `PCDC_CAP_INFO_RESET; // RULE_01
			o_dev_cap_info <= `PCDC_DEV_CAP_INFO_RESET; // RULE_12
		end else begin
			o_cap_info     <= cap_nxt;
			o_dev_cap_info <= dev_nxt;
		end
	end

	// reads see the image held before this edge, so an update in the same cycle is not yet visible
	always_comb begin
		rd_valid_nxt = i_rd;
		rd_data_nxt  = 32'h0000_0000;
		if (i_rd && i_rd_addr == `PCDC_OFS_CAP_INFO) begin
			rd_data_nxt = {16'h0000, o_cap_info}; // RULE_04
		end else if (i_rd && i_rd_addr == `PCDC_OFS_DEV_CAP_INFO) begin
			rd_data_nxt = o_dev_cap_info;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_rd_valid <= 1'h0;
			o_rd_data  <= 32'h0000_0000;
		end else begin
			o_rd_valid <= rd_valid_nxt;
			o_rd_data  <= rd_data_nxt;
		end
	end
endmodule // pcdc_regs
`default_nettype wire

// ---- rtl/pcdc_consts.svh ----
// constants for the capability and device capability register bank
`ifndef PCDC_CONSTS_SVH
`define PCDC_CONSTS_SVH
`define PCDC_OFS_CAP_INFO        8'h92
`define PCDC_OFS_DEV_CAP_INFO    8'h94
`define PCDC_OFS_GEN_CTRL        8'hD4
`define PCDC_CAP_INFO_RESET      16'h0071
`define PCDC_DEV_CAP_INFO_RESET  32'h0000_8002
`define PCDC_CAP_VERSION         4'h1
`define PCDC_PORT_KIND_CODE      4'h7
`define PCDC_ROLE_ERR_FLAG       1'h1
`define PCDC_MAX_PAYLOAD_SUPPORT 3'h2
`define PCDC_GHOST_FUNC_SUPPORT  2'h0
`define PCDC_WIDE_TAG_SUPPORT    1'h0
`define PCDC_LAT_RESET           3'h0
`define PCDC_SCALE_RESET         2'h0
`define PCDC_VALUE_RESET         8'h00
`define PCDC_GC_DEEP_HI          15
`define PCDC_GC_DEEP_LO          13
`define PCDC_GC_STBY_HI          18
`define PCDC_GC_STBY_LO          16
`define PCDC_PL_SCALE_HI         9
`define PCDC_PL_SCALE_LO         8
`endif

// ---- rtl/pcdc_pkg.sv ----
// types for the capability and device capability register bank
`default_nettype none
package pcdc_pkg;
	typedef struct packed {
		logic [1:0] captured_power_scale;
		logic [7:0] captured_power_value;
	} pcdc_power_limit_s;
	typedef struct packed {
		logic [2:0] deep_idle_exit_latency;
		logic [2:0] standby_exit_latency;
	} pcdc_latency_s;
endpackage
`default_nettype wire

// ---- sim/pcdc_regs_sva.sv ----
// assertions for the capability register bank
`timescale 1ns/1ns
`default_nettype none
module pcdc_regs_sva #(parameter logic [2:0] DMIN = 3'h0, SMIN = 3'h0) (
	input wire logic        i_clk, i_rst, i_gc_wr, i_pl_msg, i_rd, o_rd_valid,
	input wire logic [31:0] i_gc_wdata, o_rd_data, o_dev_cap_info,
	input wire logic [9:0]  i_pl_payload,
	input wire logic [7:0]  i_rd_addr,
	input wire logic [15:0] o_cap_info);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	a_cap_fixed: assert property (o_cap_info == 16'h0071) else $error("cap");
	a_dev_fixed: assert property (
		{o_dev_cap_info[31:28], o_dev_cap_info[17:12], o_dev_cap_info[5:0]} == 16'h0202) else $error("dev");
	a_pl_load: assert property (
		!i_rst && i_pl_msg |=> o_dev_cap_info[27:18] == $past(i_pl_payload)) else $error("pl");
	a_pl_hold: assert property (!i_pl_msg |=> $stable(o_dev_cap_info[27:18])) else $error("hold");
	a_deep_take: assert property (
		!i_rst && i_gc_wr && i_gc_wdata[15:13] >= DMIN |=> o_dev_cap_info[11:9] == $past(i_gc_wdata[15:13]))
		else $error("l1");
	a_deep_keep: assert property (
		!i_rst && i_gc_wr && i_gc_wdata[15:13] < DMIN |=> $stable(o_dev_cap_info[11:9])) else $error("l1k");
	a_stby_take: assert property (
		!i_rst && i_gc_wr && i_gc_wdata[18:16] >= SMIN |=> o_dev_cap_info[8:6] == $past(i_gc_wdata[18:16]))
		else $error("l0");
	a_stby_keep: assert property (
		!i_rst && i_gc_wr && i_gc_wdata[18:16] < SMIN |=> $stable(o_dev_cap_info[8:6])) else $error("l0k");
	a_rd_image: assert property (
		!i_rst && i_rd && i_rd_addr == 8'h94 |=> o_rd_valid && o_rd_data == $past(o_dev_cap_info)) else $error("rd");
	a_rd_cap: assert property (
		!i_rst && i_rd && i_rd_addr == 8'h92 |=> o_rd_valid && o_rd_data == 32'h0000_0071) else $error("rdc");
	a_rd_other: assert property (
		!i_rst && i_rd && i_rd_addr != 8'h92 && i_rd_addr != 8'h94 |=> o_rd_valid && o_rd_data == 32'h0000_0000)
		else $error("rdz");
	a_rd_idle: assert property (
		!i_rst && !i_rd |=> !o_rd_valid && o_rd_data == 32'h0000_0000) else $error("rdi");
	a_reset_image: assert property (
		disable iff (1'b0) i_rst |=> o_dev_cap_info == 32'h0000_8002 && !o_rd_valid) else $error("rst");
	c_msg: cover property (i_pl_msg);
	c_refuse: cover property (i_gc_wr && i_gc_wdata[15:13] < DMIN);
	c_read: cover property (i_rd && i_rd_addr == 8'h94);
	c_read_cap: cover property (i_rd && i_rd_addr == 8'h92);
endmodule // pcdc_regs_sva
bind pcdc_regs pcdc_regs_sva #(.DMIN(DEEP_IDLE_PHY_MIN), .SMIN(STANDBY_PHY_MIN)) i_pcdc_regs_sva(
	.i_clk(i_clk), .i_rst(i_rst), .i_gc_wr(i_gc_wr), .i_pl_msg(i_pl_msg), .i_rd(i_rd), .o_rd_valid(o_rd_valid),
	.i_gc_wdata(i_gc_wdata), .o_rd_data(o_rd_data), .o_dev_cap_info(o_dev_cap_info),
	.i_pl_payload(i_pl_payload), .i_rd_addr(i_rd_addr), .o_cap_info(o_cap_info));
`default_nettype wire

// ---- sim/pcdc_host_model.sv ----
// host model: random power messages, control writes and reads
`timescale 1ns/1ns
`default_nettype none
module pcdc_host_model(input wire logic i_clk, i_en, output logic o_pm = 0, o_gw = 0, o_rd = 0,
	output logic [31:0] o_d = 0, output logic [7:0] o_a = 0);
	logic [31:0] lfsr_r = 32'h4D84;
	function automatic logic [31:0] lfsr_step(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	always @(posedge i_clk) begin
		lfsr_r <= lfsr_step(lfsr_r);
		o_pm <= i_en & lfsr_r[3];
		o_gw <= i_en & lfsr_r[5];
		o_rd <= i_en & lfsr_r[8];
		o_d <= lfsr_r;
		// 93h is unmapped and must read zero
		o_a <= lfsr_r[9] ? 8'h94 : {7'h49, lfsr_r[10]};
	end
endmodule // pcdc_host_model
`default_nettype wire

// ---- sim/pcdc_regs_tb_top.sv ----
// bench for the capability register bank
`timescale 1ns/1ns
`default_nettype none
module pcdc_regs_tb_top;
	logic i_clk = 0, i_rst = 1, en = 0, pm, gw, rd, rv;
	logic [31:0] d, rdat, dev, ex = 32'h8002;
	logic [32:0] er = 0;
	logic [7:0] a;
	logic [15:0] cap;
	int err_count = 0, compares = 0, cyc = 0;
	initial forever #25 i_clk = ~i_clk;
	pcdc_host_model i_pcdc_host_model(.i_clk(i_clk), .i_en(en), .o_pm(pm), .o_gw(gw), .o_rd(rd), .o_d(d), .o_a(a));
	// raised minimums so that refused latency writes occur
	pcdc_regs #(.DEEP_IDLE_PHY_MIN(3'h2), .STANDBY_PHY_MIN(3'h3)) i_pcdc_regs(.i_clk(i_clk), .i_rst(i_rst),
		.i_gc_wr(gw), .i_gc_wdata(d), .i_pl_msg(pm), .i_pl_payload(d[9:0]), .i_rd(rd), .i_rd_addr(a),
		.o_rd_valid(rv), .o_rd_data(rdat), .o_cap_info(cap), .o_dev_cap_info(dev));
	function automatic logic [31:0] upd(logic [31:0] e);
		if (pm) e[27:18] = d[9:0];
		if (gw && d[15:13] >= 3'h2) e[11:9] = d[15:13];
		if (gw && d[18:16] >= 3'h3) e[8:6] = d[18:16];
		return e;
	endfunction
	task chk(logic [32:0] g, x);
		compares++;
		if (g !== x) begin
			err_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
		end
	endtask
	task close_out;
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			close_out;
		end
	end
	// pre-edge values are compared, so a read in an update cycle sees the old image
	always @(posedge i_clk) begin
		if (!i_rst) begin
			chk(dev, ex);
			chk(cap, 16'h0071);
			chk({rv, rdat}, er);
			ex <= upd(ex);
		end else ex <= 32'h8002;
		er <= (!rd || i_rst) ? 33'h0 : {1'b1, a == 8'h94 ? ex : a == 8'h92 ? 32'h71 : 32'h0};
	end
	initial begin
		repeat (4) @(posedge i_clk);
		i_rst <= 0;
		en <= 1;
		repeat (1000) @(posedge i_clk);
		$display("test random done");
		i_rst <= 1;
		repeat (2) @(posedge i_clk);
		i_rst <= 0;
		repeat (1000) @(posedge i_clk);
		$display("test reset mid run done");
		close_out;
	end
endmodule // pcdc_regs_tb_top
`default_nettype wire
